// File: rtl/fifo_flag_pkg.sv
// Shared constants and types for the dual-clock FIFO with status flags
package fifo_flag_pkg;

    localparam int DEPTH_DEF = 512;
    localparam int DATA_W_DEF = 18;
    localparam int THR_W = 12;
    localparam int SMALL_DEPTH = 512;
    localparam logic [11:0] THR_DEF_SMALL = 12'h003f;
    localparam logic [11:0] THR_DEF_LARGE = 12'h007f;
    // Wide enough for a count of 4096 plus a 12-bit threshold
    localparam int CMP_W = 14;
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] CFG_PINS_RESET = 3'h0;

    typedef enum logic {
        SEL_EMPTY = 1'b0,
        SEL_FULL = 1'b1
    } offset_sel_e;

    typedef struct packed {
        logic fall_through_mode;
        logic dbl_buf;
        logic async_partial;
    } cfg_s;

    localparam cfg_s CFG_RESET = 3'h1;

    function automatic cfg_s decode_cfg(input logic [2:0] pins);
        cfg_s c;
        logic fl;
        logic read_expand_in;
        logic write_expand_in;
        fl = pins[2];
        read_expand_in = pins[1];
        write_expand_in = pins[0];
        c.fall_through_mode = !read_expand_in && write_expand_in;
        c.dbl_buf = read_expand_in && !write_expand_in;
        c.async_partial = !fl || (fl && read_expand_in && write_expand_in);
        return c;
    endfunction : decode_cfg

endpackage : fifo_flag_pkg

// File: rtl/gray_ptr_sync.sv
// Two-stage synchroniser for a Gray-coded pointer, binary result out
`timescale 1ns/1ps
module gray_ptr_sync #(
    parameter int W = 10
) (
    input wire logic dst_clk_i,
    input wire logic dst_rst_i,
    input wire logic [W-1:0] gray_i,
    output logic [W-1:0] bin_o
);

    logic [W-1:0] meta;
    logic [W-1:0] stable;

    always_ff @(posedge dst_clk_i) begin
        if (dst_rst_i) begin
            meta <= '0;
            stable <= '0;
        end else begin
            meta <= gray_i;
            stable <= meta;
        end
    end

    // Each bit from the synchronised word only, no self-read
    always_comb begin
        for (int i = 0; i < W; i++) begin
            bin_o[i] = ^(stable >> i);
        end
    end

endmodule : gray_ptr_sync

// File: rtl/dual_clock_fifo_flag_logic.sv
// Dual-clock FIFO with empty, full, half and programmable partial flags
`timescale 1ns/1ps
module dual_clock_fifo_flag_logic #(
    parameter int DEPTH = fifo_flag_pkg::DEPTH_DEF,
    parameter int DATA_W = fifo_flag_pkg::DATA_W_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic rd_clk_i,
    input wire logic wr_en_n_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic rd_en_n_i,
    input wire logic offset_load_n_i,
    input wire logic first_load_sel_i,
    input wire logic read_expand_in_i,
    input wire logic write_expand_in_i,
    output logic [DATA_W-1:0] data_o,
    output logic empty_flag_n_o,
    output logic full_flag_n_o,
    output logic almost_empty_n_o,
    output logic almost_full_n_o,
    output logic half_full_n_o
);

    localparam int ADDR_W = $clog2(DEPTH);
    localparam int PTR_W = ADDR_W + 1;
    localparam int CW = fifo_flag_pkg::CMP_W;
    localparam int TW = fifo_flag_pkg::THR_W;
    localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
    localparam logic [PTR_W-1:0] HALF_P = PTR_W'(DEPTH / 2);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [TW-1:0] THR_DEF =
        (DEPTH == fifo_flag_pkg::SMALL_DEPTH) ?
        fifo_flag_pkg::THR_DEF_SMALL : fifo_flag_pkg::THR_DEF_LARGE;

    logic [DATA_W-1:0] mem [DEPTH];

    // ---------------- Write (core) domain ----------------
    logic [2:0] cfg_meta;
    logic [2:0] cfg_pins;
    fifo_flag_pkg::cfg_s cfg;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] wr_gray;
    logic [PTR_W-1:0] rd_ptr_w;
    logic [PTR_W-1:0] count_w;
    logic [PTR_W-1:0] next_count_w;
    logic [PTR_W-1:0] next_wr_ptr;
    logic full_raw;
    logic wr_accept;
    logic load_stb;
    logic [TW-1:0] empty_threshold;
    logic [TW-1:0] full_threshold;
    fifo_flag_pkg::offset_sel_e load_sel;
    logic [1:0] full_pipe;
    logic full_pin_raw;
    logic thr_dirty;
    logic xfer_req;
    logic [2*TW-1:0] thr_hold;
    logic ack_meta;
    logic ack_sync;
    logic af_clr_meta;
    logic af_clr_sync;
    logic next_af;
    // Driven on the read side, declared here for the crossings
    logic [PTR_W-1:0] rd_gray;
    logic ack_ack;
    logic af_clear_r;

    // Static pins, still synchronised before use
    always_ff @(posedge core_clk_i) begin
        cfg_meta <= {first_load_sel_i, read_expand_in_i, write_expand_in_i};
        cfg_pins <= cfg_meta;
    end

    // Configuration caught while reset is held
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cfg <= fifo_flag_pkg::decode_cfg(cfg_pins);
        end
    end

    assign full_raw = (count_w == DEPTH_P);
    assign wr_accept = !wr_en_n_i && offset_load_n_i && !full_raw;
    assign load_stb = !wr_en_n_i && !offset_load_n_i;
    assign count_w = wr_ptr - rd_ptr_w;
    assign next_wr_ptr = wr_ptr + PTR_W'(wr_accept);
    assign next_count_w = next_wr_ptr - rd_ptr_w;
    assign full_pin_raw = cfg.fall_through_mode ? (next_count_w == DEPTH_P) :
        (next_count_w != DEPTH_P);
    assign next_af = CW'(next_count_w) + CW'(full_threshold) >= DEPTH_C;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            wr_gray <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            wr_gray <= next_wr_ptr ^ (next_wr_ptr >> 1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (wr_accept) begin
            mem[wr_ptr[ADDR_W-1:0]] <= data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            empty_threshold <= THR_DEF;
            full_threshold <= THR_DEF;
            load_sel <= fifo_flag_pkg::SEL_EMPTY;
        end else if (load_stb) begin
            if (load_sel == fifo_flag_pkg::SEL_EMPTY) begin
                empty_threshold <= data_i[TW-1:0];
                load_sel <= fifo_flag_pkg::SEL_FULL;
            end else begin
                full_threshold <= data_i[TW-1:0];
                load_sel <= fifo_flag_pkg::SEL_EMPTY;
            end
        end
    end

    // Threshold copy to the read side by toggle handshake
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            thr_dirty <= 1'b0;
            xfer_req <= 1'b0;
            thr_hold <= {THR_DEF, THR_DEF};
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end else begin
            ack_meta <= ack_ack;
            ack_sync <= ack_meta;
            if (load_stb) begin
                thr_dirty <= 1'b1;
            end else if (thr_dirty && (ack_sync == xfer_req)) begin
                thr_dirty <= 1'b0;
            end
            if (!load_stb && thr_dirty && (ack_sync == xfer_req)) begin
                thr_hold <= {empty_threshold, full_threshold};
                xfer_req <= ~xfer_req;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            full_pipe <= 2'h3;
            full_flag_n_o <= 1'b1;
        end else begin
            full_pipe <= {full_pipe[0], full_pin_raw};
            if (cfg.fall_through_mode || cfg.dbl_buf) begin
                full_flag_n_o <= full_pipe[0];
            end else begin
                full_flag_n_o <= full_pin_raw;
            end
        end
    end

    // Half full; released on write side after read pointer arrives
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            half_full_n_o <= 1'b1;
        end else begin
            half_full_n_o <= !(next_count_w > HALF_P);
        end
    end

    // Sync update on write edges only
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            af_clr_meta <= 1'b0;
            af_clr_sync <= 1'b0;
            almost_full_n_o <= 1'b1;
        end else begin
            af_clr_meta <= af_clear_r;
            af_clr_sync <= af_clr_meta;
            if (!cfg.async_partial) begin
                almost_full_n_o <= !next_af;
            end else if (next_af) begin
                almost_full_n_o <= 1'b0;
            end else if (af_clr_sync) begin
                almost_full_n_o <= 1'b1;
            end
        end
    end

    gray_ptr_sync #(.W(PTR_W)) rd_to_wr (
        .dst_clk_i(core_clk_i),
        .dst_rst_i(rst_i),
        .gray_i(rd_gray),
        .bin_o(rd_ptr_w)
    );

    // ---------------- Read (link) domain ----------------
    logic rst_meta;
    logic rd_rst;
    logic [2:0] cfg_r_meta;
    fifo_flag_pkg::cfg_s cfg_r;
    logic ld_meta;
    logic ld_r_n;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] count_r;
    logic [PTR_W-1:0] next_count_r;
    logic [PTR_W-1:0] next_rd_ptr;
    logic empty_raw;
    logic rd_accept;
    logic ft_load;
    logic pop;
    logic rb_stb;
    logic out_valid;
    logic next_valid;
    logic ef_raw;
    logic [1:0] empty_pipe;
    fifo_flag_pkg::offset_sel_e rb_sel;
    logic req_meta;
    logic req_sync;
    logic [TW-1:0] rd_empty_thr;
    logic [TW-1:0] rd_full_thr;
    logic ae_clr_meta;
    logic ae_clr_sync;
    logic ae_clear_w;
    logic next_ae;

    // Reset reaches the read side two link edges late
    always_ff @(posedge rd_clk_i) begin
        rst_meta <= rst_i;
        rd_rst <= rst_meta;
    end

    // Config and load pin levels into the read domain
    always_ff @(posedge rd_clk_i) begin
        if (rd_rst) begin
            cfg_r_meta <= fifo_flag_pkg::CFG_PINS_RESET;
            cfg_r <= fifo_flag_pkg::CFG_RESET;
            ld_meta <= 1'b1;
            ld_r_n <= 1'b1;
        end else begin
            cfg_r_meta <= cfg;
            cfg_r <= cfg_r_meta;
            ld_meta <= offset_load_n_i;
            ld_r_n <= ld_meta;
        end
    end

    assign count_r = wr_ptr_r - rd_ptr;
    assign empty_raw = (count_r == '0);
    assign rd_accept = !rd_en_n_i && ld_r_n && !empty_raw && !cfg_r.fall_through_mode;
    assign ft_load = cfg_r.fall_through_mode && !empty_raw && (!out_valid || !rd_en_n_i);
    assign pop = rd_accept || ft_load;
    assign rb_stb = !rd_en_n_i && !ld_r_n && !cfg_r.fall_through_mode;
    assign next_rd_ptr = rd_ptr + PTR_W'(pop);
    assign next_count_r = wr_ptr_r - next_rd_ptr;
    assign next_valid = ft_load ? 1'b1 : (!rd_en_n_i ? 1'b0 : out_valid);
    assign ef_raw = cfg_r.fall_through_mode ? !next_valid : (next_count_r != '0);
    assign next_ae = CW'(next_count_r) <= CW'(rd_empty_thr);

    always_ff @(posedge rd_clk_i) begin
        if (rd_rst) begin
            rd_ptr <= '0;
            rd_gray <= '0;
            out_valid <= 1'b0;
        end else begin
            rd_ptr <= next_rd_ptr;
            rd_gray <= next_rd_ptr ^ (next_rd_ptr >> 1);
            out_valid <= cfg_r.fall_through_mode && next_valid;
        end
    end

    always_ff @(posedge rd_clk_i) begin
        if (rd_rst) begin
            data_o <= '0;
            rb_sel <= fifo_flag_pkg::SEL_EMPTY;
        end else if (pop) begin
            data_o <= mem[rd_ptr[ADDR_W-1:0]];
        end else if (rb_stb) begin
            if (rb_sel == fifo_flag_pkg::SEL_EMPTY) begin
                data_o <= DATA_W'(rd_empty_thr);
                rb_sel <= fifo_flag_pkg::SEL_FULL;
            end else begin
                data_o <= DATA_W'(rd_full_thr);
                rb_sel <= fifo_flag_pkg::SEL_EMPTY;
            end
        end
    end

    // Threshold capture; copy is held stable until acknowledged
    always_ff @(posedge rd_clk_i) begin
        if (rd_rst) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            ack_ack <= 1'b0;
            rd_empty_thr <= THR_DEF;
            rd_full_thr <= THR_DEF;
        end else begin
            req_meta <= xfer_req;
            req_sync <= req_meta;
            if (req_sync != ack_ack) begin
                {rd_empty_thr, rd_full_thr} <= thr_hold;
                ack_ack <= req_sync;
            end
        end
    end

    always_ff @(posedge rd_clk_i) begin
        if (rd_rst) begin
            empty_pipe <= 2'h0;
            empty_flag_n_o <= 1'b0;
        end else begin
            empty_pipe <= {empty_pipe[0], ef_raw};
            if (cfg_r.fall_through_mode) begin
                empty_flag_n_o <= empty_pipe[1];
            end else if (cfg_r.dbl_buf) begin
                empty_flag_n_o <= empty_pipe[0];
            end else begin
                empty_flag_n_o <= ef_raw;
            end
        end
    end

    // Sync update on read edges only
    always_ff @(posedge rd_clk_i) begin
        if (rd_rst) begin
            ae_clr_meta <= 1'b0;
            ae_clr_sync <= 1'b0;
            af_clear_r <= 1'b0;
            almost_empty_n_o <= 1'b0;
        end else begin
            ae_clr_meta <= ae_clear_w;
            ae_clr_sync <= ae_clr_meta;
            af_clear_r <= CW'(count_r) + CW'(rd_full_thr) < DEPTH_C;
            if (!cfg_r.async_partial) begin
                almost_empty_n_o <= !next_ae;
            end else if (next_ae) begin
                almost_empty_n_o <= 1'b0;
            end else if (ae_clr_sync) begin
                almost_empty_n_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ae_clear_w <= 1'b0;
        end else begin
            ae_clear_w <= CW'(next_count_w) > CW'(empty_threshold);
        end
    end

    gray_ptr_sync #(.W(PTR_W)) wr_to_rd (
        .dst_clk_i(rd_clk_i),
        .dst_rst_i(rd_rst),
        .gray_i(wr_gray),
        .bin_o(wr_ptr_r)
    );

    // Checks
    a_full_refuse: assert property (@(posedge core_clk_i) disable iff (rst_i)
        full_raw |=> wr_ptr == $past(wr_ptr))
        else $error("write taken while full");
    a_load_alt: assert property (@(posedge core_clk_i) disable iff (rst_i)
        load_stb |=> load_sel != $past(load_sel))
        else $error("offset load did not alternate");
    a_load_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        offset_load_n_i |=> $stable(load_sel))
        else $error("load position moved while load high");
    a_half_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (next_count_w == HALF_P + 1'b1) |=> !half_full_n_o)
        else $error("half full not low at half plus one");
    a_full_single: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (!cfg.fall_through_mode && !cfg.dbl_buf && !rst_i &&
        next_count_w == DEPTH_P) |=> !full_flag_n_o)
        else $error("single full flag late");
    a_full_double: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (cfg.dbl_buf && next_count_w == DEPTH_P)
        ##1 (next_count_w == DEPTH_P) |=> !full_flag_n_o)
        else $error("double full flag wrong");
    a_empty_ignore: assert property (@(posedge rd_clk_i) disable iff (rd_rst)
        empty_raw |=> rd_ptr == $past(rd_ptr))
        else $error("read taken while empty");
    a_readback: assert property (@(posedge rd_clk_i) disable iff (rd_rst)
        (rb_stb && !pop && rb_sel == fifo_flag_pkg::SEL_EMPTY)
        |=> data_o[TW-1:0] == $past(rd_empty_thr))
        else $error("empty offset not presented");
    a_ft_first: assert property (@(posedge rd_clk_i) disable iff (rd_rst)
        (cfg_r.fall_through_mode && !out_valid && !empty_raw) |=> out_valid)
        else $error("fall-through word not loaded");
    a_ae_sync: assert property (@(posedge rd_clk_i) disable iff (rd_rst)
        (!cfg_r.async_partial && next_ae) |=> !almost_empty_n_o)
        else $error("almost empty not asserted");
    c_full: cover property (@(posedge core_clk_i) disable iff (rst_i)
        !full_flag_n_o && !cfg.fall_through_mode);
    c_load_two: cover property (@(posedge core_clk_i) disable iff (rst_i)
        load_stb ##1 load_stb);
    c_readback: cover property (@(posedge rd_clk_i) disable iff (rd_rst)
        rb_stb ##1 rb_stb);
    c_drain: cover property (@(posedge rd_clk_i) disable iff (rd_rst)
        rd_accept ##1 !empty_flag_n_o);

endmodule : dual_clock_fifo_flag_logic

// File: verif/fifo_port_model.sv
// Writer and reader port model for the dual-clock FIFO
`timescale 1ns/1ps
module fifo_port_model (
    input wire logic wr_clk_i,
    input wire logic rd_clk_i,
    input wire logic [17:0] rd_data_i,
    output logic wr_en_n_o,
    output logic [17:0] wr_data_o,
    output logic rd_en_n_o,
    output logic offset_load_n_o
);
    initial begin
        wr_en_n_o = 1'b1;
        wr_data_o = 18'h0_0000;
        rd_en_n_o = 1'b1;
        offset_load_n_o = 1'b1;
    end

    task automatic push(input logic [17:0] d, input logic ld_n);
        @(posedge wr_clk_i);
        wr_en_n_o <= 1'b0;
        offset_load_n_o <= ld_n;
        wr_data_o <= d;
        @(posedge wr_clk_i);
        wr_en_n_o <= 1'b1;
        offset_load_n_o <= 1'b1;
        // Released bus shows the inverse, never a stale copy
        wr_data_o <= ~d;
    endtask : push

    // Load held low over two edges
    task automatic load2(input logic [17:0] d0, input logic [17:0] d1);
        @(posedge wr_clk_i);
        wr_en_n_o <= 1'b0;
        offset_load_n_o <= 1'b0;
        wr_data_o <= d0;
        @(posedge wr_clk_i);
        wr_data_o <= d1;
        @(posedge wr_clk_i);
        wr_en_n_o <= 1'b1;
        offset_load_n_o <= 1'b1;
        wr_data_o <= ~d1;
    endtask : load2

    task automatic pop(output logic [17:0] q);
        @(posedge rd_clk_i);
        rd_en_n_o <= 1'b0;
        @(posedge rd_clk_i);
        rd_en_n_o <= 1'b1;
        #1 q = rd_data_i;
    endtask : pop

    // load low lags two read edges
    task automatic readback(output logic [17:0] a, output logic [17:0] b);
        @(posedge wr_clk_i);
        offset_load_n_o <= 1'b0;
        repeat (4) @(posedge rd_clk_i);
        rd_en_n_o <= 1'b0;
        @(posedge rd_clk_i);
        #1 a = rd_data_i;
        @(posedge rd_clk_i);
        rd_en_n_o <= 1'b1;
        #1 b = rd_data_i;
        @(posedge wr_clk_i);
        offset_load_n_o <= 1'b1;
    endtask : readback
endmodule : fifo_port_model

// File: verif/dual_clock_fifo_flag_logic_tb_top.sv
// Testbench for the dual-clock FIFO flag logic
`timescale 1ns/1ps
module dual_clock_fifo_flag_logic_tb_top;
    logic core_clk = 1'b0;
    logic rd_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] pins = 3'h0;
    logic wr_en_n;
    logic rd_en_n;
    logic ld_n;
    logic [17:0] d_in;
    logic [17:0] d_out;
    logic ef_n, ff_n, ae_n, af_n, hf_n;
    int n_fail = 0;
    int tests_run = 0;

    always #10 core_clk = ~core_clk;
    // Link clock, free running, unrelated phase
    always #7.5 rd_clk = ~rd_clk;

    fifo_port_model port (
        .wr_clk_i(core_clk), .rd_clk_i(rd_clk), .rd_data_i(d_out),
        .wr_en_n_o(wr_en_n), .wr_data_o(d_in), .rd_en_n_o(rd_en_n),
        .offset_load_n_o(ld_n)
    );

    dual_clock_fifo_flag_logic #(.DEPTH(512), .DATA_W(18)) uut (
        .core_clk_i(core_clk), .rst_i(rst), .rd_clk_i(rd_clk),
        .wr_en_n_i(wr_en_n), .data_i(d_in), .rd_en_n_i(rd_en_n),
        .offset_load_n_i(ld_n), .first_load_sel_i(pins[2]),
        .read_expand_in_i(pins[1]), .write_expand_in_i(pins[0]),
        .data_o(d_out), .empty_flag_n_o(ef_n), .full_flag_n_o(ff_n),
        .almost_empty_n_o(ae_n), .almost_full_n_o(af_n),
        .half_full_n_o(hf_n)
    );

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    // Config pins held static across the whole reset
    task automatic do_reset(input logic [2:0] p);
        @(posedge core_clk);
        rst <= 1'b1;
        pins <= p;
        repeat (19) @(posedge core_clk);
        // Sampled off both clock edges, flags settled
        @(negedge core_clk);
        check(18'({ef_n, ff_n, ae_n, af_n, hf_n}), 18'h0_000b);
        @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge rd_clk);
    endtask : do_reset

    // Settled flags only; latency is left to the assertions
    task automatic check_flags(input int c, input int e, input int f);
        logic [4:0] exp;
        repeat (10) @(posedge rd_clk);
        // Read-side flags launch on the rising edge
        @(negedge rd_clk);
        exp = {c != 0, c != 512, c > e, c < 512 - f, c <= 256};
        check(18'({ef_n, ff_n, ae_n, af_n, hf_n}), 18'(exp));
    endtask : check_flags

    function automatic bit mark(input int c, input int e, input int f);
        return (c <= 1) || (c == e) || (c == e + 1) || (c == 256) ||
            (c == 257) || (c == 511 - f) || (c == 512 - f) || (c >= 511);
    endfunction : mark

    task automatic run_pass(input logic [2:0] p, input int e, input int f);
        logic [17:0] a;
        logic [17:0] b;
        do_reset(p);
        if (e != 63) begin
            port.load2(18'h0_0063, 18'(f));
            port.push(18'(e), 1'b0);
            repeat (12) @(posedge rd_clk);
            port.readback(a, b);
            check(a, 18'(e));
            check(b, 18'(f));
        end
        check_flags(0, e, f);
        for (int k = 1; k <= 512; k++) begin
            port.push(18'(k), 1'b1);
            if (mark(k, e, f)) check_flags(k, e, f);
        end
        port.push(18'h3_ffff, 1'b1);
        check_flags(512, e, f);
        for (int k = 1; k <= 512; k++) begin
            port.pop(a);
            check(a, 18'(k));
            if (mark(512 - k, e, f)) check_flags(512 - k, e, f);
        end
        port.pop(a);
        check(a, 18'h0_0200);
    endtask : run_pass

    task automatic fall_through_mode_pass;
        logic [17:0] a;
        logic [17:0] b;
        do_reset(3'h1);
        port.push(18'h2_aaaa, 1'b1);
        repeat (10) @(posedge rd_clk);
        @(negedge rd_clk);
        check(d_out, 18'h2_aaaa);
        check(18'(ef_n), 18'h0_0000);
        check(18'(ff_n), 18'h0_0000);
        // No offset readback in fall-through
        port.readback(a, b);
        check(a, 18'h2_aaaa);
        check(b, 18'h2_aaaa);
    endtask : fall_through_mode_pass

    initial begin
        run_pass(3'h0, 63, 63);
        run_pass(3'h6, 5, 10);
        run_pass(3'h7, 63, 63);
        fall_through_mode_pass();
        close_out();
    end

    // About 120 us expected; cut a hang well beyond that
    initial begin
        #600us;
        n_fail++;
        close_out();
    end
endmodule : dual_clock_fifo_flag_logic_tb_top
